/* File: bench/dct_pin_model.sv */
`timescale 1ns/100ps
module dct_pin_model (
  input wire logic i_out, // device drive value
  input wire logic i_oe, // device drive enable
  input wire logic i_drive, // level the far side applies
  output logic o_level // resolved line level
);
  // far side drives only while the device lets go; idle drive is high like a pull-up
  assign o_level = i_oe ? i_out : i_drive;
endmodule

/* File: bench/dct_timer_props.sv */
`timescale 1ns/100ps
module dct_timer_props (
  input wire logic i_clock, // system clock
  input wire logic i_rst, // synchronous reset
  input wire logic i_avs_read, // read request
  input wire logic i_avs_write, // write request
  input wire logic [31:0] o_avs_readdata, // read data
  input wire logic o_avs_waitrequest, // bus stall
  input wire logic i_serial_clock_req, // serial clock demand
  input wire logic o_serial_bit_tick, // serial bit pulse
  input wire logic o_irq, // interrupt request
  input wire logic o_counter_a_pin_oe, // counter a drive enable
  input wire logic o_counter_b_pin_oe, // counter b drive enable
  input wire logic o_timer_a_underflow_flag, // flag a
  input wire logic o_timer_b_underflow_flag // flag b
);
  logic any_flag;
  assign any_flag = o_timer_a_underflow_flag | o_timer_b_underflow_flag;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_wait_answer: assert property (
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("request not answered in one cycle");
  a_wait_single: assert property (
    !o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_read_upper_zero: assert property (
    !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bytes not zero");
  a_reset_state: assert property (
    $fell(i_rst) |-> o_avs_waitrequest && !o_irq && !any_flag
      && !o_counter_a_pin_oe && !o_counter_b_pin_oe)
    else $error("outputs not at reset values");
  a_irq_no_flag: assert property (
    !any_flag |=> !o_irq)
    else $error("interrupt without underflow flag");
  a_irq_has_cause: assert property (
    $rose(o_irq) |-> $past(any_flag))
    else $error("interrupt rose without a flag before it");
  a_tick_single: assert property (
    o_serial_bit_tick |=> !o_serial_bit_tick [*8])
    else $error("serial ticks too close");
  a_tick_req: assert property (
    o_serial_bit_tick |-> $past(i_serial_clock_req))
    else $error("serial tick without request");
  a_serial_no_oe: assert property (
    i_serial_clock_req [*2] |-> !o_counter_a_pin_oe)
    else $error("counter a pin driven while serial forced");
  cover property (o_serial_bit_tick);
  cover property ($rose(o_irq));
  cover property ($rose(o_counter_b_pin_oe));
  cover property ($fell(o_timer_a_underflow_flag));
endmodule

/* File: bench/test_dual_counter_timer.sv */
`timescale 1ns/100ps
module test_dual_counter_timer;
  logic i_clock = 1'h0;
  logic i_rst = 1'h1;
  logic [7:0] i_avs_address = 8'h00;
  logic i_avs_read = 1'h0;
  logic i_avs_write = 1'h0;
  logic [31:0] i_avs_writedata = 32'h00000000;
  logic [3:0] i_avs_byteenable = 4'hF;
  logic i_serial_clock_req = 1'h0;
  logic a_drive = 1'h1;
  logic b_drive = 1'h1;
  logic a_level, b_level;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest, o_serial_bit_tick, o_irq;
  logic o_counter_a_pin, o_counter_a_pin_oe, o_counter_b_pin, o_counter_b_pin_oe;
  logic o_timer_a_underflow_flag, o_timer_b_underflow_flag;
  int err_total = 0;
  int tests_run = 0;
  int n;

  dct_timer dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_serial_clock_req(i_serial_clock_req),
    .o_serial_bit_tick(o_serial_bit_tick), .o_irq(o_irq), .i_counter_a_pin(a_level),
    .o_counter_a_pin(o_counter_a_pin), .o_counter_a_pin_oe(o_counter_a_pin_oe),
    .i_counter_b_pin(b_level), .o_counter_b_pin(o_counter_b_pin),
    .o_counter_b_pin_oe(o_counter_b_pin_oe),
    .o_timer_a_underflow_flag(o_timer_a_underflow_flag),
    .o_timer_b_underflow_flag(o_timer_b_underflow_flag));
  dct_pin_model pin_a_u (.i_out(o_counter_a_pin), .i_oe(o_counter_a_pin_oe),
    .i_drive(a_drive), .o_level(a_level));
  dct_pin_model pin_b_u (.i_out(o_counter_b_pin), .i_oe(o_counter_b_pin_oe),
    .i_drive(b_drive), .o_level(b_level));

  always #10 i_clock = ~i_clock;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // request held until waitrequest is seen low, then released
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d,
      output logic [7:0] q);
    int k;
    k = 0;
    @(posedge i_clock);
    i_avs_address <= {idx, 2'h0};
    i_avs_writedata <= {24'h000000, d};
    i_avs_read <= ~wr;
    i_avs_write <= wr;
    do begin
      @(posedge i_clock);
      k++;
    end while (o_avs_waitrequest !== 1'h0 && k < 50);
    q = o_avs_readdata[7:0];
    i_avs_read <= 1'h0;
    i_avs_write <= 1'h0;
    if (k >= 50) chk("bus answer", 16'h0000, 16'h0001);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'h1, idx, d, q);
  endtask

  task automatic rc(input string nm, input logic [5:0] idx, input logic [7:0] e);
    logic [7:0] q;
    bus(1'h0, idx, 8'h00, q);
    chk(nm, {8'h00, q}, {8'h00, e});
  endtask

  function automatic logic pick(input int sel);
    logic [2:0] v;
    v = {o_serial_bit_tick, o_timer_b_underflow_flag, o_timer_a_underflow_flag};
    return v[sel];
  endfunction

  task automatic wait_hi(input int sel, input int lim, output int c);
    c = 0;
    while (pick(sel) !== 1'h1 && c < lim) begin
      @(posedge i_clock);
      c++;
    end
    chk("awaited signal", 16'(pick(sel)), 16'h0001);
  endtask

  task automatic pin_a(input logic v, input int cyc);
    a_drive <= v;
    repeat (cyc) @(posedge i_clock);
  endtask

  task automatic span(output int c);
    logic s;
    c = 0;
    s = o_counter_b_pin;
    while (o_counter_b_pin === s && c < 300) begin
      @(posedge i_clock);
      c++;
    end
  endtask

  initial begin
    repeat (40000) @(posedge i_clock);
    err_total++;
    finish_test();
  end

  initial begin
    repeat (5) @(posedge i_clock);
    i_rst <= 1'h0;
    @(posedge i_clock);
    chk("pin a oe", 16'(o_counter_a_pin_oe), 16'h0000);
    rc("ctrl", dct_pkg::IDX_CTRL, 8'h00);
    // write without lane 0 is answered but ignored
    i_avs_byteenable <= 4'h0;
    wr(dct_pkg::IDX_CTRL, 8'h30);
    i_avs_byteenable <= 4'hF;
    rc("ctrl lanes", dct_pkg::IDX_CTRL, 8'h00);
    rc("status", dct_pkg::IDX_STATUS, 8'h3C);
    rc("b high", dct_pkg::IDX_B_HIGH, 8'hFF);
    rc("a high", dct_pkg::IDX_A_HIGH, 8'hFF);
    rc("unmapped", 6'h3F, 8'h00);
    wr(dct_pkg::IDX_A_LOW, 8'h00);
    wr(dct_pkg::IDX_A_HIGH, 8'h01);
    rc("a high", dct_pkg::IDX_A_HIGH, 8'hFF);
    wr(dct_pkg::IDX_A_RELOAD, 8'h01);
    rc("a high", dct_pkg::IDX_A_HIGH, 8'h00);
    wr(dct_pkg::IDX_CTRL, 8'h10);
    wait_hi(0, 300, n);
    repeat (2) @(posedge i_clock);
    chk("irq", 16'(o_irq), 16'h0001);
    // reload to 0100 at the underflow edge, then seven clocks to the low sample
    rc("a high", dct_pkg::IDX_A_HIGH, 8'h00);
    rc("a low", dct_pkg::IDX_A_LOW, 8'hF9);
    @(posedge i_clock);
    chk("flag a", 16'(o_timer_a_underflow_flag), 16'h0000);
    wait_hi(0, 300, n);
    wr(dct_pkg::IDX_A_RELOAD, 8'h01);
    @(posedge i_clock);
    chk("flag a", 16'(o_timer_a_underflow_flag), 16'h0000);
    // pulse output: high on entry, low on reload, toggles on underflow
    wr(dct_pkg::IDX_CTRL, 8'h01);
    repeat (2) @(posedge i_clock);
    chk("a oe", 16'(o_counter_a_pin_oe), 16'h0001);
    chk("a out", 16'(o_counter_a_pin), 16'h0001);
    wr(dct_pkg::IDX_A_RELOAD, 8'h01);
    @(posedge i_clock);
    chk("a out", 16'(o_counter_a_pin), 16'h0000);
    wait_hi(0, 300, n);
    @(posedge i_clock);
    chk("a out", 16'(o_counter_a_pin), 16'h0001);
    // event mode: five rising edges
    wr(dct_pkg::IDX_CTRL, 8'h02);
    wr(dct_pkg::IDX_A_RELOAD, 8'h01);
    repeat (5) begin
      pin_a(1'h0, 2);
      pin_a(1'h1, 2);
    end
    pin_a(1'h1, 6);
    rc("a low", dct_pkg::IDX_A_LOW, 8'hFB);
    // width mode: held while high, counts while low
    wr(dct_pkg::IDX_CTRL, 8'h03);
    wr(dct_pkg::IDX_A_RELOAD, 8'h01);
    rc("a low", dct_pkg::IDX_A_RELOAD, 8'h00);
    pin_a(1'h0, 16);
    pin_a(1'h1, 8);
    rc("a low", dct_pkg::IDX_A_RELOAD, 8'hF0);
    pin_a(1'h0, 4);
    pin_a(1'h1, 8);
    rc("a low", dct_pkg::IDX_A_RELOAD, 8'hEC);
    // serial: latch 0001 underflows every 2 cycles, tick every 32
    wr(dct_pkg::IDX_CTRL, 8'h01);
    wr(dct_pkg::IDX_A_LOW, 8'h01);
    wr(dct_pkg::IDX_A_RELOAD, 8'h00);
    i_serial_clock_req <= 1'h1;
    wait_hi(2, 100, n);
    @(posedge i_clock);
    wait_hi(2, 100, n);
    chk("tick gap", 16'(n), 16'h001F);
    chk("a oe", 16'(o_counter_a_pin_oe), 16'h0000);
    i_serial_clock_req <= 1'h0;
    // retrigger: edges every 200 cycles keep a 256 count from expiring
    wr(dct_pkg::IDX_CTRL, 8'h0C);
    wr(dct_pkg::IDX_B_LOW, 8'h00);
    wr(dct_pkg::IDX_B_HIGH, 8'h01);
    wr(dct_pkg::IDX_B_RELOAD, 8'h01);
    rc("b high", dct_pkg::IDX_B_HIGH, 8'h00);
    repeat (4) begin
      b_drive <= 1'h0;
      repeat (100) @(posedge i_clock);
      b_drive <= 1'h1;
      repeat (100) @(posedge i_clock);
    end
    chk("flag b", 16'(o_timer_b_underflow_flag), 16'h0000);
    wait_hi(1, 300, n);
    rc("b low", dct_pkg::IDX_B_LOW, 8'hFE);
    @(posedge i_clock);
    chk("flag b", 16'(o_timer_b_underflow_flag), 16'h0000);
    // counter B event mode: three rising edges
    wr(dct_pkg::IDX_CTRL, 8'h08);
    wr(dct_pkg::IDX_B_RELOAD, 8'h01);
    repeat (3) begin
      b_drive <= 1'h0;
      repeat (2) @(posedge i_clock);
      b_drive <= 1'h1;
      repeat (2) @(posedge i_clock);
    end
    repeat (6) @(posedge i_clock);
    rc("b low", dct_pkg::IDX_B_RELOAD, 8'hFD);
    // asymmetric: high phase from latch c 0010, low phase from latch b 0040
    wr(dct_pkg::IDX_CTRL, 8'h04);
    wr(dct_pkg::IDX_B_LOW, 8'h10);
    wr(dct_pkg::IDX_B_HIGH, 8'h00);
    wr(dct_pkg::IDX_B_LOW, 8'h40);
    wr(dct_pkg::IDX_B_RELOAD, 8'h00);
    @(posedge i_clock);
    chk("b oe", 16'(o_counter_b_pin_oe), 16'h0001);
    chk("b out", 16'(o_counter_b_pin), 16'h0000);
    span(n);
    span(n);
    chk("b high span", 16'(n), 16'h0011);
    span(n);
    chk("b low span", 16'(n), 16'h0041);
    // second reset in mid-run
    i_rst <= 1'h1;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'h0;
    rc("ctrl", dct_pkg::IDX_CTRL, 8'h00);
    chk("flag a", 16'(o_timer_a_underflow_flag), 16'h0000);
    finish_test();
  end
endmodule

bind dct_timer dct_timer_props u_props (.i_clock(i_clock), .i_rst(i_rst),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_serial_clock_req(i_serial_clock_req),
  .o_serial_bit_tick(o_serial_bit_tick), .o_irq(o_irq),
  .o_counter_a_pin_oe(o_counter_a_pin_oe), .o_counter_b_pin_oe(o_counter_b_pin_oe),
  .o_timer_a_underflow_flag(o_timer_a_underflow_flag),
  .o_timer_b_underflow_flag(o_timer_b_underflow_flag));

/* File: verilog/dct_pkg.sv */
package dct_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned MODE_W = 2;

  // register index; byte address is four times this
  localparam logic [5:0] IDX_STATUS = 6'h11;
  localparam logic [5:0] IDX_CTRL = 6'h14;
  localparam logic [5:0] IDX_A_LOW = 6'h18;
  localparam logic [5:0] IDX_A_HIGH = 6'h19;
  localparam logic [5:0] IDX_A_RELOAD = 6'h1A;
  localparam logic [5:0] IDX_B_LOW = 6'h1C;
  localparam logic [5:0] IDX_B_HIGH = 6'h1D;
  localparam logic [5:0] IDX_B_RELOAD = 6'h1E;

  // control register fields
  localparam int unsigned CTRL_A_MODE_LSB = 0;
  localparam int unsigned CTRL_B_MODE_LSB = 2;
  localparam int unsigned CTRL_A_IRQ_EN = 4;
  localparam int unsigned CTRL_B_IRQ_EN = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // status register fields
  localparam int unsigned ST_A_FLAG = 0;
  localparam int unsigned ST_B_FLAG = 1;
  localparam int unsigned ST_A_PIN = 2;
  localparam int unsigned ST_B_PIN = 3;
  localparam int unsigned ST_A_OUT = 4;
  localparam int unsigned ST_B_OUT = 5;

  localparam logic [1:0] MODE_A_INTERVAL = 2'h0;
  localparam logic [1:0] MODE_A_PULSE = 2'h1;
  localparam logic [1:0] MODE_A_EVENT = 2'h2;
  localparam logic [1:0] MODE_A_WIDTH = 2'h3;

  localparam logic [1:0] MODE_B_INTERVAL = 2'h0;
  localparam logic [1:0] MODE_B_ASYM = 2'h1;
  localparam logic [1:0] MODE_B_EVENT = 2'h2;
  localparam logic [1:0] MODE_B_RETRIG = 2'h3;

  localparam logic [15:0] COUNT_RESET = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [3:0] SER_DIV_LAST = 4'hF;
  localparam logic [3:0] SER_DIV_ZERO = 4'h0;
  localparam logic [3:0] SER_DIV_ONE = 4'h1;
  localparam logic PIN_RESET = 1'b1;
  localparam int unsigned PIN_COUNT = 2;
  localparam int unsigned PIN_A = 0;
  localparam int unsigned PIN_B = 1;
endpackage

/* File: verilog/dct_sync.sv */
`timescale 1ns/100ps
module dct_sync (
  input wire logic i_clock, // system clock
  input wire logic i_rst, // synchronous reset, active high
  input wire logic i_async, // level from a pin
  output logic o_sync // level after two flops
);
  logic stage1_reg;
  logic stage2_reg;

  // first stage feeds only the second stage
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      stage1_reg <= dct_pkg::PIN_RESET;
      stage2_reg <= dct_pkg::PIN_RESET;
    end else begin
      stage1_reg <= i_async;
      stage2_reg <= stage1_reg;
    end
  end

  assign o_sync = stage2_reg;
endmodule

/* File: verilog/dct_timer.sv */
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/100ps
module dct_timer (
  input wire logic i_clock, // 50 MHz system clock
  input wire logic i_rst, // synchronous reset, active high
  input wire logic [7:0] i_avs_address, // byte address
  input wire logic i_avs_read, // read request
  input wire logic i_avs_write, // write request
  input wire logic [31:0] i_avs_writedata, // write data, low byte used
  input wire logic [3:0] i_avs_byteenable, // byte lanes
  output logic [31:0] o_avs_readdata, // read data, low byte valid
  output logic o_avs_waitrequest, // high while access pending
  input wire logic i_serial_clock_req, // serial port needs counter A clock
  output logic o_serial_bit_tick, // pulse every sixteenth A underflow
  output logic o_irq, // interrupt request, active high
  input wire logic i_counter_a_pin, // counter A pin level
  output logic o_counter_a_pin, // counter A pin drive value
  output logic o_counter_a_pin_oe, // counter A pin drive enable
  input wire logic i_counter_b_pin, // counter B pin level
  output logic o_counter_b_pin, // counter B pin drive value
  output logic o_counter_b_pin_oe, // counter B pin drive enable
  output logic o_timer_a_underflow_flag, // counter A underflow flag
  output logic o_timer_b_underflow_flag // counter B underflow flag
);
  // bus side
  logic wait_reg;
  logic [31:0] readdata_reg;
  logic [7:0] readbyte;
  logic [5:0] idx;
  logic [7:0] wdata;
  logic bus_req;
  logic wr_fire;
  logic rd_fire;

  // register state
  logic [7:0] ctrl_reg;
  logic [15:0] latch_a_reg;
  logic [15:0] latch_b_reg;
  logic [15:0] latch_c_reg;
  logic [15:0] count_a_reg;
  logic [15:0] count_a_next;
  logic [15:0] count_b_reg;
  logic [15:0] count_b_next;
  logic timer_a_underflow_flag_reg;
  logic timer_b_underflow_flag_reg;

  // decoded accesses
  logic wr_ctrl;
  logic wr_a_low;
  logic wr_a_high;
  logic wr_a_reload;
  logic wr_b_low;
  logic wr_b_high;
  logic wr_b_reload;
  logic rd_a_clear;
  logic rd_b_clear;

  // counting
  logic [1:0] mode_a_eff;
  logic [1:0] mode_b;
  logic [1:0] mode_a_prev_reg;
  logic [1:0] mode_b_prev_reg;
  logic dec_a;
  logic dec_b;
  logic uf_a;
  logic uf_b;
  logic retrig_b;
  logic [15:0] reload_b;

  // pins
  logic [dct_pkg::PIN_COUNT-1:0] pin_raw;
  logic [dct_pkg::PIN_COUNT-1:0] pin_sync;
  logic [dct_pkg::PIN_COUNT-1:0] pin_prev_reg;
  logic [dct_pkg::PIN_COUNT-1:0] pin_rise;
  logic pin_a_out_reg;
  logic pin_b_out_reg;
  logic pin_a_oe_reg;
  logic pin_b_oe_reg;

  // serial and interrupt
  logic [3:0] ser_div_reg;
  logic ser_tick_reg;
  logic irq_reg;

  assign pin_raw[dct_pkg::PIN_A] = i_counter_a_pin;
  assign pin_raw[dct_pkg::PIN_B] = i_counter_b_pin;

  // both pins come from outside the clock domain
  genvar gi;
  generate
    for (gi = 0; gi < dct_pkg::PIN_COUNT; gi = gi + 1) begin : g_pin
      dct_sync u_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_async(pin_raw[gi]),
        .o_sync(pin_sync[gi])
      );

      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          pin_prev_reg[gi] <= dct_pkg::PIN_RESET;
        end else begin
          pin_prev_reg[gi] <= pin_sync[gi];
        end
      end

      assign pin_rise[gi] = pin_sync[gi] & ~pin_prev_reg[gi];
    end
  endgenerate

  // bus handshake: one wait cycle, access acts on the release edge
  assign bus_req = i_avs_read | i_avs_write;
  assign wr_fire = i_avs_write & ~wait_reg & i_avs_byteenable[0];
  assign rd_fire = i_avs_read & ~wait_reg;
  assign idx = i_avs_address[dct_pkg::ADDR_W-1:2];
  assign wdata = i_avs_writedata[7:0];

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wait_reg <= 1'b1;
    end else if (bus_req && !wait_reg) begin
      wait_reg <= 1'b1;
    end else if (bus_req) begin
      wait_reg <= 1'b0;
    end
  end

  assign wr_ctrl = wr_fire && (idx == dct_pkg::IDX_CTRL);
  assign wr_a_low = wr_fire && (idx == dct_pkg::IDX_A_LOW);
  assign wr_a_high = wr_fire && (idx == dct_pkg::IDX_A_HIGH);
  assign wr_a_reload = wr_fire && (idx == dct_pkg::IDX_A_RELOAD);
  assign wr_b_low = wr_fire && (idx == dct_pkg::IDX_B_LOW);
  assign wr_b_high = wr_fire && (idx == dct_pkg::IDX_B_HIGH);
  assign wr_b_reload = wr_fire && (idx == dct_pkg::IDX_B_RELOAD);
  assign rd_a_clear = rd_fire && (idx == dct_pkg::IDX_A_LOW);
  assign rd_b_clear = rd_fire && (idx == dct_pkg::IDX_B_LOW);

  always_comb begin
    readbyte = 8'h00;
    case (idx)
      dct_pkg::IDX_STATUS: begin
        readbyte[dct_pkg::ST_A_FLAG] = timer_a_underflow_flag_reg;
        readbyte[dct_pkg::ST_B_FLAG] = timer_b_underflow_flag_reg;
        readbyte[dct_pkg::ST_A_PIN] = pin_sync[dct_pkg::PIN_A];
        readbyte[dct_pkg::ST_B_PIN] = pin_sync[dct_pkg::PIN_B];
        readbyte[dct_pkg::ST_A_OUT] = pin_a_out_reg;
        readbyte[dct_pkg::ST_B_OUT] = pin_b_out_reg;
      end
      dct_pkg::IDX_CTRL: begin
        readbyte = ctrl_reg;
      end
      dct_pkg::IDX_A_LOW, dct_pkg::IDX_A_RELOAD: begin
        readbyte = count_a_reg[7:0];
      end
      dct_pkg::IDX_A_HIGH: begin
        readbyte = count_a_reg[15:8];
      end
      dct_pkg::IDX_B_LOW, dct_pkg::IDX_B_RELOAD: begin
        readbyte = count_b_reg[7:0];
      end
      dct_pkg::IDX_B_HIGH: begin
        readbyte = count_b_reg[15:8];
      end
      default: begin
        readbyte = 8'h00;
      end
    endcase
  end

  // data captured as waitrequest drops, stands through the taking edge
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      readdata_reg <= 32'h0000_0000;
    end else if (i_avs_read && wait_reg) begin
      readdata_reg <= {24'h00_0000, readbyte};
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ctrl_reg <= dct_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= wdata;
    end
  end

  // reset gives interval mode; serial forces clock count
  assign mode_a_eff = i_serial_clock_req ? dct_pkg::MODE_A_INTERVAL :
                      ctrl_reg[dct_pkg::CTRL_A_MODE_LSB +: dct_pkg::MODE_W];
  assign mode_b = ctrl_reg[dct_pkg::CTRL_B_MODE_LSB +: dct_pkg::MODE_W];

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      mode_a_prev_reg <= dct_pkg::MODE_A_INTERVAL;
      mode_b_prev_reg <= dct_pkg::MODE_B_INTERVAL;
    end else begin
      mode_a_prev_reg <= mode_a_eff;
      mode_b_prev_reg <= mode_b;
    end
  end

  always_comb begin
    dec_a = 1'b0;
    case (mode_a_eff)
      dct_pkg::MODE_A_INTERVAL, dct_pkg::MODE_A_PULSE: begin
        dec_a = 1'b1;
      end
      dct_pkg::MODE_A_EVENT: begin
        dec_a = pin_rise[dct_pkg::PIN_A];
      end
      dct_pkg::MODE_A_WIDTH: begin
        dec_a = ~pin_sync[dct_pkg::PIN_A];
      end
      default: begin
        dec_a = 1'b0;
      end
    endcase
  end

  always_comb begin
    count_a_next = count_a_reg;
    uf_a = 1'b0;
    if (wr_a_reload) begin
      count_a_next = {wdata, latch_a_reg[7:0]};
    end else if (dec_a) begin
      // reload instead of wrap; same in width mode
      if (count_a_reg == dct_pkg::COUNT_ZERO) begin
        count_a_next = latch_a_reg;
        uf_a = 1'b1;
      end else begin
        count_a_next = count_a_reg - dct_pkg::COUNT_ONE;
      end
    end
  end

  // counters start from latch, count down
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      count_a_reg <= dct_pkg::COUNT_RESET;
      count_b_reg <= dct_pkg::COUNT_RESET;
    end else begin
      count_a_reg <= count_a_next;
      count_b_reg <= count_b_next;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      latch_a_reg <= dct_pkg::COUNT_RESET;
    end else if (wr_a_low) begin
      latch_a_reg[7:0] <= wdata;
    end else if (wr_a_high || wr_a_reload) begin
      latch_a_reg[15:8] <= wdata;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      timer_a_underflow_flag_reg <= 1'b0;
    end else if (uf_a) begin
      timer_a_underflow_flag_reg <= 1'b1;
    end else if (wr_a_reload || rd_a_clear) begin
      timer_a_underflow_flag_reg <= 1'b0;
    end
  end

  // toggle on underflow; high on entry, low on reload write
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pin_a_out_reg <= dct_pkg::PIN_RESET;
    end else if (mode_a_eff == dct_pkg::MODE_A_PULSE) begin
      if (mode_a_prev_reg != dct_pkg::MODE_A_PULSE) begin
        pin_a_out_reg <= 1'b1;
      end else if (wr_a_reload) begin
        pin_a_out_reg <= 1'b0;
      end else if (uf_a) begin
        pin_a_out_reg <= ~pin_a_out_reg;
      end
    end
  end

  // pin A driven only in pulse mode, pin B only in asymmetric mode
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pin_a_oe_reg <= 1'b0;
      pin_b_oe_reg <= 1'b0;
    end else begin
      pin_a_oe_reg <= (mode_a_eff == dct_pkg::MODE_A_PULSE);
      pin_b_oe_reg <= (mode_b == dct_pkg::MODE_B_ASYM);
    end
  end

  always_comb begin
    dec_b = 1'b0;
    case (mode_b)
      dct_pkg::MODE_B_INTERVAL, dct_pkg::MODE_B_ASYM: begin
        dec_b = 1'b1;
      end
      dct_pkg::MODE_B_RETRIG: begin
        dec_b = 1'b1;
      end
      dct_pkg::MODE_B_EVENT: begin
        dec_b = pin_rise[dct_pkg::PIN_B];
      end
      default: begin
        dec_b = 1'b0;
      end
    endcase
  end

  assign retrig_b = (mode_b == dct_pkg::MODE_B_RETRIG) && pin_rise[dct_pkg::PIN_B];

  // low phase ends into pulse width from latch C
  assign reload_b = ((mode_b == dct_pkg::MODE_B_ASYM) && !pin_b_out_reg) ?
                    latch_c_reg : latch_b_reg;

  always_comb begin
    count_b_next = count_b_reg;
    uf_b = 1'b0;
    if (wr_b_reload) begin
      count_b_next = {wdata, latch_b_reg[7:0]};
    end else if (retrig_b) begin
      count_b_next = latch_b_reg;
    end else if (dec_b) begin
      if (count_b_reg == dct_pkg::COUNT_ZERO) begin
        count_b_next = reload_b;
        uf_b = 1'b1;
      end else begin
        count_b_next = count_b_reg - dct_pkg::COUNT_ONE;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      latch_b_reg <= dct_pkg::COUNT_RESET;
    end else if (wr_b_low) begin
      latch_b_reg[7:0] <= wdata;
    end else if (wr_b_high || wr_b_reload) begin
      latch_b_reg[15:8] <= wdata;
    end
  end

  // high write in asym mode fills latch C
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      latch_c_reg <= dct_pkg::COUNT_RESET;
    end else if (wr_b_high && (mode_b == dct_pkg::MODE_B_ASYM)) begin
      latch_c_reg <= {wdata, latch_b_reg[7:0]};
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      timer_b_underflow_flag_reg <= 1'b0;
    end else if (uf_b) begin
      timer_b_underflow_flag_reg <= 1'b1;
    end else if (wr_b_reload || rd_b_clear) begin
      timer_b_underflow_flag_reg <= 1'b0;
    end
  end

  // reload write low, then alternate on underflow
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pin_b_out_reg <= dct_pkg::PIN_RESET;
    end else if (mode_b == dct_pkg::MODE_B_ASYM) begin
      if (mode_b_prev_reg != dct_pkg::MODE_B_ASYM) begin
        pin_b_out_reg <= 1'b1;
      end else if (wr_b_reload) begin
        pin_b_out_reg <= 1'b0;
      end else if (uf_b) begin
        pin_b_out_reg <= ~pin_b_out_reg;
      end
    end
  end

  // bit clock at one sixteenth of underflow rate
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ser_div_reg <= dct_pkg::SER_DIV_ZERO;
      ser_tick_reg <= 1'b0;
    end else if (!i_serial_clock_req) begin
      ser_div_reg <= dct_pkg::SER_DIV_ZERO;
      ser_tick_reg <= 1'b0;
    end else if (uf_a) begin
      ser_div_reg <= ser_div_reg + dct_pkg::SER_DIV_ONE;
      ser_tick_reg <= (ser_div_reg == dct_pkg::SER_DIV_LAST);
    end else begin
      ser_tick_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (timer_a_underflow_flag_reg & ctrl_reg[dct_pkg::CTRL_A_IRQ_EN]) |
                 (timer_b_underflow_flag_reg & ctrl_reg[dct_pkg::CTRL_B_IRQ_EN]);
    end
  end

  assign o_avs_readdata = readdata_reg;
  assign o_avs_waitrequest = wait_reg;
  assign o_serial_bit_tick = ser_tick_reg;
  assign o_irq = irq_reg;
  assign o_counter_a_pin = pin_a_out_reg;
  assign o_counter_a_pin_oe = pin_a_oe_reg;
  assign o_counter_b_pin = pin_b_out_reg;
  assign o_counter_b_pin_oe = pin_b_oe_reg;
  assign o_timer_a_underflow_flag = timer_a_underflow_flag_reg;
  assign o_timer_b_underflow_flag = timer_b_underflow_flag_reg;
endmodule
